// ==== src/spgp_pin_mux.sv ====
// Per-pin drive and readback mux for the shared pins
`timescale 1ns/1ps
`default_nettype none
module spgp_pin_mux
	import spgp_pkg::*;
(
	input  wire logic [7:0] func_en,   // Digital function per pin
	input  wire logic [7:0] dir,       // 1 input, 0 output
	input  wire logic [7:0] level_reg, // Stored level bits
	input  wire logic [7:0] pin_in_q,  // Sampled pin levels
	output logic      [7:0] drive_en,  // Pin output enables
	output logic      [7:0] drive_val, // Pin output levels
	output logic      [7:0] readback   // Value seen by software
);
	// Drive only digital pins set as outputs; analog pins stay released
	always_comb begin
		for (int i = 0; i < SPGP_NPINS; i++) begin
			drive_en[i]  = func_en[i] && (dir[i] == SPGP_DIR_OUT);
			drive_val[i] = level_reg[i];
			// Output reads register, input reads pin
			readback[i]  = (dir[i] == SPGP_DIR_IN) ? pin_in_q[i]
			                                       : level_reg[i];
		end
	end
endmodule
`default_nettype wire

// ==== src/spgp_pkg.sv ====
// Package of register map constants for the shared pin port
package spgp_pkg;
	localparam int          SPGP_NPINS          = 8;     // Pins in full variant
	localparam logic [11:0] SPGP_FUNC_EN_INDEX  = 12'h00C; // Function enable
	localparam logic [11:0] SPGP_DIR_INDEX      = 12'h00D; // Direction
	localparam logic [11:0] SPGP_DATA_INDEX     = 12'h00E; // Level data
	localparam logic [7:0]  SPGP_FUNC_EN_RESET  = 8'h00;
	localparam logic [7:0]  SPGP_DIR_RESET      = 8'h00;   // All outputs
	localparam logic [7:0]  SPGP_DATA_RESET     = 8'h00;   // All low
	localparam logic [7:0]  SPGP_NARROW_MASK    = 8'h0F;   // Four-pin bits
	localparam logic [1:0]  SPGP_WORD_LSB       = 2'h0;    // Word alignment
	localparam logic        SPGP_DIR_OUT        = 1'b0;    // Output code
	localparam logic        SPGP_DIR_IN         = 1'b1;    // Input code
endpackage

// ==== src/spgp_top.sv ====
// Top of the shared pin digital port with APB register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Direction bit zero output, one input
// - Level data at 0x0E, resets zero
// - Output pin reads back stored register
// - Input pin write stores only, no drive
// - Data zero low, one high, low default
// - Bits 0,1 references, 2-7 analog inputs
// - Four-pin variant: bits 7:4 read zero
// - Function enable at 0x0C gates digital use
// - Direction register at 0x0D, resets zero
module spgp_top
	import spgp_pkg::*;
#(
	parameter bit FOUR_PIN = 1'b0 // Narrow variant select
)(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [7:0]  pin_in,  // Pin levels, bit 0 positive ref
	output logic      [7:0]  pin_out, // Driven levels
	output logic      [7:0]  pin_oe   // High while driving
);
	// Whole module state in one struct
	typedef struct packed {
		logic [7:0]  func_en;   // Function enable bits
		logic [7:0]  dir;       // Direction bits
		logic [7:0]  level;     // Level data bits
		logic [7:0]  pin_s;     // Sampled pins
		logic [31:0] rdata;     // Read data
		logic        ready;     // Access answer
		logic        err;       // Unmapped answer
		logic [7:0]  oe;        // Registered enables
		logic [7:0]  outv;      // Registered levels
	} spgp_state_s;

	spgp_state_s st_q;          // Current state
	spgp_state_s st_d;          // Next state
	logic [7:0]  drive_en;      // From pin mux
	logic [7:0]  drive_val;     // From pin mux
	logic [7:0]  readback;      // From pin mux
	logic [7:0]  impl_mask;     // Implemented bits

	// Mask out the reserved upper half in the narrow variant
	assign impl_mask = FOUR_PIN ? SPGP_NARROW_MASK : 8'hFF;

	// Decode a byte address into a register index match
	function automatic logic hit(input logic [31:0] a,
	                             input logic [11:0] idx);
		hit = (a[31:2] == {18'h00000, idx}) && (a[1:0] == SPGP_WORD_LSB);
	endfunction

	spgp_pin_mux u_mux (
		.func_en   (st_q.func_en),
		.dir       (st_q.dir),
		.level_reg (st_q.level),
		.pin_in_q  (st_q.pin_s),
		.drive_en  (drive_en),
		.drive_val (drive_val),
		.readback  (readback)
	);

	// Next state: APB slave, one wait state so ready comes from a flop
	always_comb begin
		logic acc;
		logic mapped;
		acc    = 1'b0;
		mapped = 1'b0;
		st_d       = st_q;
		st_d.pin_s = pin_in & impl_mask;
		st_d.oe    = drive_en & impl_mask;
		st_d.outv  = drive_val & impl_mask;
		st_d.ready = 1'b0;
		st_d.err   = 1'b0;
		acc    = psel && penable && !st_q.ready;
		mapped = hit(paddr, SPGP_FUNC_EN_INDEX) ||
		         hit(paddr, SPGP_DIR_INDEX) ||
		         hit(paddr, SPGP_DATA_INDEX);
		if (acc) begin
			st_d.ready = 1'b1;
			st_d.err   = !mapped;
			st_d.rdata = 32'h00000000;
			if (pwrite) begin
				// Writes always store; drive follows function enable and direction
				if (hit(paddr, SPGP_FUNC_EN_INDEX))
					st_d.func_en = pwdata[7:0] & impl_mask;
				if (hit(paddr, SPGP_DIR_INDEX))
					st_d.dir = pwdata[7:0] & impl_mask;
				if (hit(paddr, SPGP_DATA_INDEX))
					st_d.level = pwdata[7:0] & impl_mask;
			end else begin
				// Reads: unmapped gives zero with error
				if (hit(paddr, SPGP_FUNC_EN_INDEX))
					st_d.rdata = {24'h000000, st_q.func_en};
				if (hit(paddr, SPGP_DIR_INDEX))
					st_d.rdata = {24'h000000, st_q.dir};
				if (hit(paddr, SPGP_DATA_INDEX))
					st_d.rdata = {24'h000000, readback & impl_mask};
			end
		end
	end

	// State register with constant reset values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q         <= '0;
			st_q.func_en <= SPGP_FUNC_EN_RESET;
			st_q.dir     <= SPGP_DIR_RESET;
			st_q.level   <= SPGP_DATA_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign prdata  = st_q.rdata;
	assign pready  = st_q.ready;
	assign pslverr = st_q.err;
	assign pin_out = st_q.outv;
	assign pin_oe  = st_q.oe;

	// Pin drives stored level when digital output
	property p_drive_level;
		@(posedge pclk) disable iff (!presetn)
		(st_q.func_en[0] && !st_q.dir[0]) |=> (pin_oe[0] &&
		 pin_out[0] == $past(st_q.level[0]));
	endproperty
	a_drive_level: assert property (p_drive_level)
		else $error("output pin not driving stored level");

	// Input pin never driven
	property p_input_released;
		@(posedge pclk) disable iff (!presetn)
		st_q.dir[1] |=> !pin_oe[1];
	endproperty
	a_input_released: assert property (p_input_released)
		else $error("input pin driven");

	// Analog pin never driven
	property p_analog_released;
		@(posedge pclk) disable iff (!presetn)
		!st_q.func_en[2] |=> !pin_oe[2];
	endproperty
	a_analog_released: assert property (p_analog_released)
		else $error("analog pin driven");

	// Data write lands in the level register
	sequence s_data_write;
		psel && penable && pwrite && !pready && hit(paddr, SPGP_DATA_INDEX);
	endsequence
	property p_data_write;
		@(posedge pclk) disable iff (!presetn)
		s_data_write |=> (st_q.level == ($past(pwdata[7:0]) & impl_mask));
	endproperty
	a_data_write: assert property (p_data_write)
		else $error("level write lost");

	// Direction write lands in the direction register
	property p_dir_write;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && !pready && hit(paddr, SPGP_DIR_INDEX))
		|=> (st_q.dir == ($past(pwdata[7:0]) & impl_mask));
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction write lost");

	// Input read returns sampled pin
	property p_input_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && !pready &&
		 hit(paddr, SPGP_DATA_INDEX) && st_q.dir[3])
		|=> (prdata[3] == $past(st_q.pin_s[3]));
	endproperty
	a_input_read: assert property (p_input_read)
		else $error("input read not pin level");

	// Narrow variant keeps upper bits zero
	property p_narrow_zero;
		@(posedge pclk) disable iff (!presetn)
		FOUR_PIN |-> (prdata[7:4] == 4'h0 && pin_oe[7:4] == 4'h0);
	endproperty
	a_narrow_zero: assert property (p_narrow_zero)
		else $error("reserved bits nonzero");

	// Access answered in exactly one wait state
	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		(psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("answer timing wrong");

	// Function enable write lands, reserved bits dropped
	property p_func_write;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && !pready &&
		 hit(paddr, SPGP_FUNC_EN_INDEX))
		|=> (st_q.func_en == ($past(pwdata[7:0]) & impl_mask));
	endproperty
	a_func_write: assert property (p_func_write)
		else $error("function enable write lost");

	// Output pin read returns stored level, not the pin
	property p_output_read;
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pwrite && !pready &&
		 hit(paddr, SPGP_DATA_INDEX) && !st_q.dir[0])
		|=> (prdata[0] == $past(st_q.level[0]));
	endproperty
	a_output_read: assert property (p_output_read)
		else $error("output read not stored level");
endmodule
`default_nettype wire

// ==== test/spgp_pin_model.sv ====
// Outside circuitry model on the shared pins
`timescale 1ns/1ps
`default_nettype none
module spgp_pin_model (
	input  wire logic [7:0] pin_out, // Device drive levels
	input  wire logic [7:0] pin_oe,  // Device drive enables
	input  wire logic [7:0] ext_lvl, // Outside level
	output logic      [7:0] pin_in   // Resolved pin level
);
	// Device wins where it drives
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

// ==== test/test_spgp_top.sv ====
// Self-checking bench for the shared pin port
`timescale 1ns/1ps
`default_nettype none
module test_spgp_top;
	import spgp_pkg::*;
	logic        pclk = 0;
	logic        presetn = 0;   // Held low at start
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [31:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic [31:0] prdata_n;      // Narrow variant
	logic        pready;
	logic        pready_n;
	logic        pslverr;
	logic        pslverr_n;
	logic [7:0]  ext_lvl = 0;   // Outside pin levels
	logic [7:0]  pin_in;
	logic [7:0]  pin_in_n;
	logic [7:0]  pin_out;
	logic [7:0]  pin_out_n;
	logic [7:0]  pin_oe;
	logic [7:0]  pin_oe_n;
	int          miscompares = 0;
	int          n_compared = 0;
	int          mr[3];         // Model: enable, direction, data
	int          ex;            // Model of outside level
	logic [31:0] rd;
	logic [31:0] rdn;
	logic        er;
	logic        ern;           // Narrow variant error
	logic        rn;            // Narrow variant ready
	// Free running clock
	always #2.5 pclk = ~pclk;
	spgp_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
		.pin_out, .pin_oe);
	// Narrow variant shares the bus, answers in step
	spgp_top #(.FOUR_PIN(1'b1)) dut_n (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata(prdata_n),
		.pready(pready_n), .pslverr(pslverr_n), .pin_in(pin_in_n),
		.pin_out(pin_out_n), .pin_oe(pin_oe_n));
	spgp_pin_model pm_w (.pin_out, .pin_oe, .ext_lvl, .pin_in);
	spgp_pin_model pm_n (.pin_out(pin_out_n), .pin_oe(pin_oe_n),
		.ext_lvl, .pin_in(pin_in_n));
	// Single exit point
	task automatic give_verdict();
		$display("compared %0d miscompares %0d", n_compared,
			miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// One APB transfer; entered just after a rising edge
	task automatic apb(input logic w, input int idx, input int wd);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= 32'(idx) << 2;
		pwdata <= 32'(wd);
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		rdn = prdata_n;
		er = pslverr;
		ern = pslverr_n;
		rn = pready_n;
		psel <= 1'b0;
		penable <= 1'b0;
		// A hung slave ends the run
		if (k >= 20) begin
			miscompares++;
			give_verdict();
		end
		// Idle edge so a following setup never reassigns psel now
		@(posedge pclk);
	endtask
	// Read all registers and compare pins with the model
	task automatic check_all();
		int e;
		for (int j = 0; j < 3; j++) begin
			e = (j < 2) ? mr[j] : (mr[2] & ~mr[1]) | (ex & mr[1]);
			apb(1'b0, int'(SPGP_FUNC_EN_INDEX) + j, 0);
			chk(32'(e), rd);
			chk(32'(e & 8'h0F), rdn);
			chk(32'h0, 32'(er));
			chk(32'h0, 32'(ern));
			chk(32'h1, 32'(rn));
		end
		e = mr[0] & ~mr[1];
		chk(32'(e), 32'(pin_oe));
		chk(32'(mr[2] & e), 32'(pin_out & pin_oe));
		chk(32'(e & 8'h0F), 32'(pin_oe_n));
		chk(32'(mr[2] & e & 8'h0F), 32'(pin_out_n & pin_oe_n));
	endtask
	// Reset, then random register traffic against the model
	initial begin
		void'($urandom(32'h8581CF15));
		mr = '{0, 0, 0};
		ex = 0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 60; i++) begin
			int a;
			int d;
			check_all();
			a = $urandom_range(2);
			d = $urandom & 8'hFF;
			mr[a] = d;
			apb(1'b1, int'(SPGP_FUNC_EN_INDEX) + a, d);
			ex = $urandom & 8'hFF;
			ext_lvl <= 8'(ex);
		end
		check_all();
		// Unmapped word: refused with an error, reads zero
		apb(1'b0, 15, 0);
		chk(32'h0, rd);
		chk(32'h1, 32'(er));
		chk(32'h1, 32'(ern));
		// Mid-run reset: every register back to zero
		presetn <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		mr = '{0, 0, 0};
		@(posedge pclk);
		check_all();
		give_verdict();
	end
endmodule
`default_nettype wire
